//--- hw/sarsc_ctrl.sv
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
module sarsc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // trigger sources and rc oscillator tick
  input wire logic ext_int_edge,
  input wire logic timer_compare,
  input wire logic pwm_interval,
  input wire logic rc_tick,
  // analog front end
  input wire logic [11:0] sar_result,
  output logic sample_connect,
  output logic [3:0] mux_pos,
  output logic mux_neg,
  output logic sar_start,
  output logic sar_bit_clk,
  output logic conv_active,
  output logic upper_ref_ext,
  output logic lower_ref_ext,
  // event
  output logic converter_irq_flag
);

  sarsc_pkg::sarsc_state_s_t st;
  sarsc_pkg::sarsc_state_s_t nx;
  logic tick;
  logic trig;
  logic [15:0] rd_word;

  // ****************************************
  // helpers
  // ****************************************
  // lowest selected input above cur, else lowest selected input
  function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] lo;
    logic [3:0] hi;
    logic found;
    lo = 4'h0;
    hi = 4'h0;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i]) begin
        lo = 4'(i);
        if (i > int'(cur)) begin
          hi = 4'(i);
          found = 1'b1;
        end
      end
    end
    return found ? hi : lo;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nx = st;
    tick = 1'b0;
    trig = 1'b0;
    nx.sar_start = 1'b0;
    nx.bit_clk = 1'b0;
    nx.irq = 1'b0;
    nx.buf_we = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        sarsc_pkg::OFF_CTRL1: begin
          nx.on = reg_wdata[sarsc_pkg::C1_ON];
          nx.trigger_source_select = reg_wdata[sarsc_pkg::C1_TRIGGER_SOURCE_SELECT +: 3];
          nx.auto_sample_start = reg_wdata[sarsc_pkg::C1_AUTO_SAMPLE_START];
          nx.sample_enable_bit = reg_wdata[sarsc_pkg::C1_SAMPLE_ENABLE_BIT];
          nx.done = st.done & reg_wdata[sarsc_pkg::C1_DONE];
        end
        sarsc_pkg::OFF_CTRL2: begin
          nx.reference_config = reg_wdata[sarsc_pkg::C2_REFERENCE_CONFIG +: 3];
          nx.cscna = reg_wdata[sarsc_pkg::C2_CSCNA];
          nx.sequences_per_interrupt = reg_wdata[sarsc_pkg::C2_SEQUENCES_PER_INTERRUPT +: 4];
          nx.buffer_split_mode = reg_wdata[sarsc_pkg::C2_BUFFER_SPLIT_MODE];
          nx.alternate_inputs = reg_wdata[sarsc_pkg::C2_ALTERNATE_INPUTS];
        end
        sarsc_pkg::OFF_CTRL3: begin
          nx.auto_sample_time = reg_wdata[sarsc_pkg::C3_AUTO_SAMPLE_TIME +: 5];
          nx.rc_clock_select = reg_wdata[sarsc_pkg::C3_RC];
          nx.conv_clock_divisor = reg_wdata[sarsc_pkg::C3_DIV +: 6];
        end
        sarsc_pkg::OFF_INSEL: nx.insel = reg_wdata & sarsc_pkg::INSEL_MASK;
        sarsc_pkg::OFF_SCAN: nx.scan_sel = reg_wdata;
        default: ;
      endcase
    end
    // conversion clock period
    if (!st.on) begin
      nx.tad_cnt = 6'h00;
    end else if (st.rc_clock_select) begin
      tick = rc_tick;
      nx.tad_cnt = 6'h00;
    end else if (st.tad_cnt == st.conv_clock_divisor) begin
      tick = 1'b1;
      nx.tad_cnt = 6'h00;
    end else begin
      nx.tad_cnt = st.tad_cnt + 6'h01;
    end
    case (st.trigger_source_select)
      sarsc_pkg::TRIG_EXT: trig = ext_int_edge;
      sarsc_pkg::TRIG_TMR: trig = timer_compare;
      sarsc_pkg::TRIG_PWM: trig = pwm_interval;
      sarsc_pkg::TRIG_AUTO: trig = (st.sample_enable_bit_cnt >= st.auto_sample_time);
      default: trig = 1'b0;
    endcase
    unique case (st.state)
      sarsc_pkg::ST_IDLE: begin
        if (nx.on && (nx.sample_enable_bit || nx.auto_sample_start)) begin
          nx.state = sarsc_pkg::ST_SAMPLE;
          nx.sample_enable_bit = 1'b1;
          nx.sample_enable_bit_cnt = 5'h00;
        end
      end
      sarsc_pkg::ST_SAMPLE: begin
        if (tick && st.sample_enable_bit_cnt != 5'h1f) begin
          nx.sample_enable_bit_cnt = st.sample_enable_bit_cnt + 5'h01;
        end
        if (trig || (st.trigger_source_select == sarsc_pkg::TRIG_SW && !nx.sample_enable_bit)) begin
          nx.state = sarsc_pkg::ST_CONVERT;
          nx.sample_enable_bit = 1'b0;
          nx.done = 1'b0;
          nx.sar_start = 1'b1;
          nx.bit_cnt = 4'h0;
          nx.tad_cnt = 6'h00;
        end else if (!nx.sample_enable_bit) begin
          nx.state = sarsc_pkg::ST_IDLE;
        end
      end
      sarsc_pkg::ST_CONVERT: begin
        if (tick) begin
          nx.bit_clk = 1'b1;
          if (st.bit_cnt == sarsc_pkg::CONV_LAST) begin
            nx.buf_we = 1'b1;
            nx.buf_waddr = st.wr_idx;
            nx.buf_wdata = sar_result;
            nx.done = 1'b1;
            if (st.seq_cnt == st.sequences_per_interrupt) begin
              nx.irq = 1'b1;
              nx.seq_cnt = 4'h0;
              nx.bufs = st.buffer_split_mode & ~st.bufs;
              nx.wr_idx = (st.buffer_split_mode && !st.bufs) ? sarsc_pkg::HALF_BASE : 4'h0;
              nx.scan_pos = next_scan(st.scan_sel, 4'hf);
            end else begin
              nx.seq_cnt = st.seq_cnt + 4'h1;
              nx.wr_idx = st.wr_idx + 4'h1;
              if (!st.alt_b) begin
                nx.scan_pos = next_scan(st.scan_sel, st.scan_pos);
              end
            end
            nx.alt_b = st.alternate_inputs & ~st.alt_b;
            if (st.auto_sample_start) begin
              nx.sample_enable_bit = 1'b1;
              nx.sample_enable_bit_cnt = 5'h00;
              nx.state = sarsc_pkg::ST_SAMPLE;
            end else begin
              nx.state = sarsc_pkg::ST_IDLE;
            end
          end else begin
            nx.bit_cnt = st.bit_cnt + 4'h1;
          end
        end
      end
      default: nx.state = sarsc_pkg::ST_IDLE;
    endcase
    if (!nx.on) begin
      nx.state = sarsc_pkg::ST_IDLE;
      nx.seq_cnt = 4'h0;
      nx.wr_idx = 4'h0;
      nx.bufs = 1'b0;
      nx.alt_b = 1'b0;
      nx.scan_pos = next_scan(nx.scan_sel, 4'hf);
    end
    nx.sh_connect = (nx.state == sarsc_pkg::ST_SAMPLE);
    nx.conv_active = (nx.state == sarsc_pkg::ST_CONVERT);
    if (nx.alt_b) begin
      nx.mux_pos = nx.insel[sarsc_pkg::IS_POS_B +: 4];
      nx.mux_neg = nx.insel[sarsc_pkg::IS_NEG_B];
    end else begin
      nx.mux_pos = nx.cscna ? nx.scan_pos : nx.insel[sarsc_pkg::IS_POS_A +: 4];
      nx.mux_neg = nx.insel[sarsc_pkg::IS_NEG_A];
    end
    nx.ref_hi_ext = (nx.reference_config == 3'h1) || (nx.reference_config == 3'h3);
    nx.ref_lo_ext = (nx.reference_config == 3'h2) || (nx.reference_config == 3'h3);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= sarsc_pkg::ST_IDLE;
    end else begin
      st <= nx;
    end
  end

  // ****************************************
  // register read and result buffer
  // ****************************************
  always_comb begin
    rd_word = sarsc_pkg::RST_WORD;
    case (reg_addr)
      sarsc_pkg::OFF_CTRL1: rd_word = {st.on, 7'h00, st.trigger_source_select, 2'h0, st.auto_sample_start, st.sample_enable_bit, st.done};
      sarsc_pkg::OFF_CTRL2: rd_word = {st.reference_config, 2'h0, st.cscna, 2'h0, st.bufs, 1'b0, st.sequences_per_interrupt, st.buffer_split_mode, st.alternate_inputs};
      sarsc_pkg::OFF_CTRL3: rd_word = {3'h0, st.auto_sample_time, st.rc_clock_select, 1'b0, st.conv_clock_divisor};
      sarsc_pkg::OFF_INSEL: rd_word = st.insel;
      sarsc_pkg::OFF_SCAN: rd_word = st.scan_sel;
      default: rd_word = sarsc_pkg::RST_WORD;
    endcase
  end

  sarsc_result_mem u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(st.buf_we),
    .wr_addr(st.buf_waddr),
    .wr_data(st.buf_wdata),
    .rd_en(reg_rd),
    .rd_mem(reg_addr[7:6] == sarsc_pkg::BUF_PAGE),
    .rd_addr(reg_addr[5:2]),
    .bypass_data(rd_word),
    .rd_data(reg_rdata)
  );

  assign sample_connect = st.sh_connect;
  assign mux_pos = st.mux_pos;
  assign mux_neg = st.mux_neg;
  assign sar_start = st.sar_start;
  assign sar_bit_clk = st.bit_clk;
  assign conv_active = st.conv_active;
  assign upper_ref_ext = st.ref_hi_ext;
  assign lower_ref_ext = st.ref_lo_ext;
  assign converter_irq_flag = st.irq;

  // ****************************************
  // checks
  // ****************************************
  logic [4:0] chk_ticks;
  logic [4:0] chk_seqs;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_ticks <= 5'h00;
      chk_seqs <= 5'h00;
    end else begin
      chk_ticks <= st.sar_start ? 5'h00 : (chk_ticks + {4'h0, st.bit_clk});
      if (st.irq || !st.on) begin
        chk_seqs <= 5'h00;
      end else if (st.buf_we) begin
        chk_seqs <= chk_seqs + 5'h01;
      end
    end
  end

  chk_conv_periods: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.buf_we |-> st.bit_clk && chk_ticks + 5'h01 == 5'(sarsc_pkg::CONV_PERIODS)) else $error("conversion not 14 periods");
  chk_hold_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_active |-> !sample_connect) else $error("sample-hold connected while converting");
  chk_done_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.buf_we |-> st.done && !conv_active) else $error("done not set on completion");
  chk_irq_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    converter_irq_flag |-> chk_seqs == {1'b0, st.sequences_per_interrupt}) else $error("interrupt at wrong sequence count");
  chk_auto_resample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.buf_we && st.auto_sample_start && st.on |-> sample_connect && st.sample_enable_bit) else $error("no resample after conversion");
  chk_ref_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    upper_ref_ext == (st.reference_config == 3'h1 || st.reference_config == 3'h3)
    && lower_ref_ext == (st.reference_config == 3'h2 || st.reference_config == 3'h3)) else $error("reference select wrong");
  chk_rc_clock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sar_bit_clk && $past(st.rc_clock_select) |-> $past(rc_tick)) else $error("bit clock without rc tick");
  chk_div_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.on && !st.rc_clock_select && $stable(st.conv_clock_divisor) |-> st.tad_cnt <= st.conv_clock_divisor) else $error("divisor count overrun");
  chk_ext_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.state == sarsc_pkg::ST_SAMPLE && st.trigger_source_select == sarsc_pkg::TRIG_EXT && ext_int_edge && st.on
    && !reg_wr |=> conv_active && sar_start) else $error("external trigger missed");
  chk_idx_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    converter_irq_flag |-> st.wr_idx == (st.bufs ? sarsc_pkg::HALF_BASE : 4'h0)) else $error("index not reset");
  chk_off_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st.on |-> !conv_active && !sample_connect) else $error("active while off");

endmodule

//--- hw/sarsc_pkg.sv
package sarsc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CTRL3 = 8'h08;
  localparam logic [7:0] OFF_INSEL = 8'h0c;
  localparam logic [7:0] OFF_SCAN = 8'h10;
  localparam logic [1:0] BUF_PAGE = 2'h1;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] INSEL_MASK = 16'h1f1f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int C1_ON = 15;
  localparam int C1_TRIGGER_SOURCE_SELECT = 5;
  localparam int C1_AUTO_SAMPLE_START = 2;
  localparam int C1_SAMPLE_ENABLE_BIT = 1;
  localparam int C1_DONE = 0;
  localparam int C2_REFERENCE_CONFIG = 13;
  localparam int C2_CSCNA = 10;
  localparam int C2_BUFS = 7;
  localparam int C2_SEQUENCES_PER_INTERRUPT = 2;
  localparam int C2_BUFFER_SPLIT_MODE = 1;
  localparam int C2_ALTERNATE_INPUTS = 0;
  localparam int C3_AUTO_SAMPLE_TIME = 8;
  localparam int C3_RC = 7;
  localparam int C3_DIV = 0;
  localparam int IS_POS_A = 0;
  localparam int IS_NEG_A = 4;
  localparam int IS_POS_B = 8;
  localparam int IS_NEG_B = 12;

  // ****************************************
  // trigger codes and timing
  // ****************************************
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EXT = 3'h1;
  localparam logic [2:0] TRIG_TMR = 3'h2;
  localparam logic [2:0] TRIG_PWM = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam int RES_BITS = 12;
  localparam int BUF_DEPTH = 16;
  localparam logic [3:0] CONV_PERIODS = 4'he;
  localparam logic [3:0] CONV_LAST = CONV_PERIODS - 4'h1;
  localparam logic [3:0] HALF_BASE = 4'h8;
  // instruction cycle is two ref_clk cycles, so one divisor step is one ref_clk cycle
  localparam int TCY_CYCLES = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } sarsc_state_t;

  typedef struct packed {
    sarsc_state_t state;
    logic on;
    logic [2:0] trigger_source_select;
    logic auto_sample_start;
    logic sample_enable_bit;
    logic done;
    logic [2:0] reference_config;
    logic cscna;
    logic [3:0] sequences_per_interrupt;
    logic buffer_split_mode;
    logic alternate_inputs;
    logic bufs;
    logic [4:0] auto_sample_time;
    logic rc_clock_select;
    logic [5:0] conv_clock_divisor;
    logic [15:0] insel;
    logic [15:0] scan_sel;
    logic [5:0] tad_cnt;
    logic [3:0] bit_cnt;
    logic [4:0] sample_enable_bit_cnt;
    logic [3:0] seq_cnt;
    logic [3:0] wr_idx;
    logic alt_b;
    logic [3:0] scan_pos;
    logic sh_connect;
    logic conv_active;
    logic sar_start;
    logic bit_clk;
    logic irq;
    logic [3:0] mux_pos;
    logic mux_neg;
    logic ref_hi_ext;
    logic ref_lo_ext;
    logic buf_we;
    logic [3:0] buf_waddr;
    logic [11:0] buf_wdata;
  } sarsc_state_s_t;

endpackage

//--- hw/sarsc_result_mem.sv
`timescale 1ns/10ps
module sarsc_result_mem (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [11:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic rd_mem,
  input wire logic [3:0] rd_addr,
  input wire logic [15:0] bypass_data,
  output logic [15:0] rd_data
);

  logic [11:0] mem [sarsc_pkg::BUF_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read word is the buffer entry or the register word, always from this flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= sarsc_pkg::RST_WORD;
    end else if (rd_en) begin
      rd_data <= rd_mem ? {4'h0, mem[rd_addr]} : bypass_data;
    end else begin
      rd_data <= sarsc_pkg::RST_WORD;
    end
  end

endmodule

//--- sim/sarsc_afe_model.sv
`timescale 1ns/10ps
module sarsc_afe_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control from the sequencer
  input wire logic [3:0] mux_pos,
  input wire logic mux_neg,
  input wire logic sar_start,
  input wire logic conv_active,
  // result to the sequencer
  output logic [11:0] sar_result
);
  logic [11:0] held;
  logic [11:0] noise;

  // ****************************************
  // held code and idle noise
  // ****************************************
  // code is built from the input selected when the hold begins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 12'h000;
      noise <= 12'h000;
    end else begin
      noise <= noise + 12'h9e7;
      if (sar_start) begin
        held <= {mux_neg, 7'h35, mux_pos};
      end
    end
  end

  // no valid result outside a conversion, so it keeps moving
  assign sar_result = conv_active ? held : noise;
endmodule

//--- sim/tb_sar_adc_sequence_control.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb_sar_adc_sequence_control;
  logic ref_clk, rst_n, reg_wr, reg_rd, ext_int_edge, timer_compare, pwm_interval, rc_en;
  logic rc_tick = 1'b0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] sar_result;
  logic [3:0] mux_pos, pa, pb;
  logic mux_neg, nb, sample_connect, sar_start, sar_bit_clk, conv_active;
  logic upper_ref_ext, lower_ref_ext, converter_irq_flag;
  logic [11:0] seen[$];
  int num_errors = 0, checked = 0, n_start = 0, n_irq = 0, n_done = 0, n_bits = 0;
  int sc_len = 0, last_len = 0, exp_per, rc_cnt = 0, d, k, i0, auto_sample_time, lo, hi, ln;
  time last_t;
  logic ca_q = 1'b0;
  bit stopping = 1'b0;
  bit auto_on = 1'b0;
  localparam int RC_PER = 84;

  sarsc_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_int_edge(ext_int_edge),
    .timer_compare(timer_compare), .pwm_interval(pwm_interval), .rc_tick(rc_tick),
    .sar_result(sar_result), .sample_connect(sample_connect), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .sar_start(sar_start), .sar_bit_clk(sar_bit_clk), .conv_active(conv_active),
    .upper_ref_ext(upper_ref_ext), .lower_ref_ext(lower_ref_ext),
    .converter_irq_flag(converter_irq_flag));
  sarsc_afe_model u_afe (.ref_clk(ref_clk), .rst_n(rst_n), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .sar_start(sar_start), .conv_active(conv_active), .sar_result(sar_result));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // slow oscillator tick, period kept above the minimum conversion-clock period
  always @(posedge ref_clk) begin
    rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
    rc_tick <= rc_en && rc_cnt == RC_PER - 1;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] res_of(input logic [3:0] p, input logic n);
    return {n, 7'h35, p};
  endfunction
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic pulse(input int w);
    @(posedge ref_clk);
    ext_int_edge <= (w == 1);
    timer_compare <= (w == 2);
    pwm_interval <= (w == 3);
    @(posedge ref_clk);
    {ext_int_edge, timer_compare, pwm_interval} <= 3'h0;
  endtask
  task automatic wait_n(input int w, input int n);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge ref_clk);
      #1;
      if ((w == 0 ? n_start : w == 1 ? n_irq : n_done) >= n) break;
    end
    if (i == 5000) begin
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      stop_test();
    end
  endtask

  // ****************************************
  // monitor of the analog side
  // ****************************************
  always @(posedge ref_clk) begin
    if (sar_start === 1'b1) begin
      n_start++;
      n_bits = 0;
      seen.push_back(res_of(mux_pos, mux_neg));
    end
    if (sar_bit_clk === 1'b1) begin
      n_bits++;
      // last period ends the hold, auto start reconnects at once
      `CHK(sample_connect, 1'(n_bits == 14 && auto_on))
      if (n_bits > 1) `CHK(int'((($time - last_t) / 4)), exp_per)
      last_t = $time;
    end
    if (rst_n && ca_q && conv_active === 1'b0) begin
      n_done++;
      if (!stopping) `CHK(n_bits, 14)
    end
    ca_q = conv_active;
    if (converter_irq_flag === 1'b1) n_irq++;
    if (sample_connect === 1'b1) sc_len++;
    else if (sc_len != 0) begin
      last_len = sc_len;
      sc_len = 0;
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    {reg_wr, reg_rd, ext_int_edge, timer_compare, pwm_interval, rc_en} = 6'h00;
    exp_per = 1;
    void'($urandom(32'h027c));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 5; a++) rchk(8'(4 * a), 16'h0000);
    rchk(8'h20, 16'h0000);
    `CHK({sample_connect, conv_active, upper_ref_ext, lower_ref_ext}, 4'h0)
    for (int v = 0; v < 8; v++) begin
      wr(sarsc_pkg::OFF_CTRL2, 16'(v << 13));
      tick(3);
      `CHK({upper_ref_ext, lower_ref_ext}, v[2] ? 2'b00 : {v[0], v[1]})
    end
    $display("reset and reference test done");
    d = $urandom % 4;
    exp_per = d + 1;
    pa = 4'($urandom);
    wr(sarsc_pkg::OFF_CTRL3, 16'(d));
    wr(sarsc_pkg::OFF_INSEL, {12'h000, pa});
    wr(sarsc_pkg::OFF_CTRL2, 16'h0000);
    wr(sarsc_pkg::OFF_CTRL1, 16'h8002);
    tick(4);
    `CHK(sample_connect, 1'b1)
    k = n_done;
    i0 = n_irq;
    seen.delete();
    wr(sarsc_pkg::OFF_CTRL1, 16'h8000);
    wait_n(2, k + 1);
    tick(2);
    rchk(sarsc_pkg::OFF_CTRL1, 16'h8001);
    rchk(8'h40, {4'h0, res_of(pa, 1'b0)});
    `CHK(n_irq, i0 + 1)
    wr(sarsc_pkg::OFF_CTRL1, 16'h8000);
    rchk(sarsc_pkg::OFF_CTRL1, 16'h8000);
    $display("manual test done");
    for (int c = 1; c < 7; c++) begin
      wr(sarsc_pkg::OFF_CTRL1, 16'(c << 5));
      wr(sarsc_pkg::OFF_CTRL1, 16'h8002 | 16'(c << 5));
      tick(3);
      k = n_start;
      for (int e = 1; e < 4; e++) if (e != c) pulse(e);
      tick(3);
      `CHK(n_start, k)
      if (c < 4) begin
        pulse(c);
        wait_n(0, k + 1);
        wait_n(2, n_done + 1);
      end
    end
    wr(sarsc_pkg::OFF_CTRL1, 16'h0000);
    $display("trigger test done");
    auto_sample_time = 1 + $urandom % 6;
    pb = 4'($urandom);
    nb = 1'($urandom);
    lo = $urandom % 8;
    hi = 8 + $urandom % 8;
    wr(sarsc_pkg::OFF_CTRL3, 16'(auto_sample_time << 8 | d));
    wr(sarsc_pkg::OFF_INSEL, {3'h0, nb, pb, 8'h10});
    wr(sarsc_pkg::OFF_SCAN, 16'(1 << lo | 1 << hi));
    wr(sarsc_pkg::OFF_CTRL2, 16'h040f);
    seen.delete();
    i0 = n_irq;
    auto_on = 1'b1;
    wr(sarsc_pkg::OFF_CTRL1, 16'h80e6);
    wait_n(1, i0 + 2);
    ln = last_len;
    // turning off may cut a conversion short
    stopping = 1'b1;
    wr(sarsc_pkg::OFF_CTRL1, 16'h0000);
    for (int j = 0; j < 8; j++)
      `CHK(seen[j], res_of(j % 2 ? pb : (j % 4 ? 4'(hi) : 4'(lo)), j % 2 ? nb : 1'b1))
    for (int j = 0; j < 8; j++) rchk(8'(8'h40 + 4 * (j < 4 ? j : j + 4)), {4'h0, seen[j]});
    `CHK(ln >= (auto_sample_time - 1) * (d + 1) && ln <= (auto_sample_time + 2) * (d + 1) + 3, 1'b1)
    $display("auto test done");
    exp_per = RC_PER;
    stopping = 1'b0;
    auto_on = 1'b0;
    rc_en <= 1'b1;
    wr(sarsc_pkg::OFF_CTRL3, 16'h00bf);
    wr(sarsc_pkg::OFF_CTRL2, 16'h0000);
    wr(sarsc_pkg::OFF_CTRL1, 16'h8002);
    tick(4);
    k = n_done;
    wr(sarsc_pkg::OFF_CTRL1, 16'h8000);
    wait_n(2, k + 1);
    $display("oscillator test done");
    stop_test();
  end
endmodule
